// ==== three_wire_serial_defs.svh ====
// constants of the three-wire serial channel: offsets, fields, reset values, timing
// assumes an 8-bit internal bus with a 16-bit address and a 200 MHz system clock
//
// Behaviour
// - three modes: stopped, plain three-wire, three-wire with automatic transfer handshake
// - when stopped, no shifting; shift register is plain 8-bit read/write storage
// - when stopped, serial pins are released for use as ordinary port pins
// - reset clears the serial mode/control register to zero
// - clock source: high bit 0 pin clock; 10 timer two; 11 timer clock select
// - mode bit 0 selects plain three-wire, 1 selects automatic transfer mode
// - direction bit 6: 0 sends MSB first, 1 sends LSB first
// - LSB-first made by reversing bits between bus and shift register, both ways
// - data moves in 8-bit units, one bit per serial clock cycle
// - shift on serial clock falling edge; output bit held in an output latch
// - serial input sampled into shift register on serial clock rising edge
// - after eight bits shifting stops and the done flag is set
// - writing the shift register forces the serial output low
// - a write starts only if enabled and clock stopped or clock line high
// - setting enable after the data write does not start a transfer
// - automatic mode moves one byte per shift register write, as plain mode does
// - automatic mode with internal clock paces bytes with strobe and busy handshake lines
`ifndef THREE_WIRE_SERIAL_DEFS_SVH
`define THREE_WIRE_SERIAL_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SMC_OFFSET 16'hff68
`define SHIFT_OFFSET 16'hff69
`define SMC_RESET 8'h00
`define SMC_WRITE_MASK 8'he3

// ----------------------------------------
// control fields
// ----------------------------------------
`define SMC_ENABLE_BIT 7
`define SMC_DIR_BIT 6
`define SMC_AUTO_BIT 5
`define SMC_CLK_HI_BIT 1
`define SMC_CLK_LO_BIT 0

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define STROBE_NS 20
`define STROBE_CYCLES ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BITS_PER_WORD 8
`define MAX_AUTO_BYTES 32

`endif

// ==== three_wire_serial_pkg.sv ====
// types of the three-wire serial channel
// assumes nothing beyond the constants header
package three_wire_serial_pkg;

    typedef enum logic {XS_IDLE, XS_RUN} xfer_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] sreg;
        logic [7:0] rdata;
        xfer_state_t state;
        logic [3:0] cnt;
        logic so;
        logic so_oe_n;
        logic sck_o;
        logic sck_oe_n;
        logic stb;
        logic stb_oe_n;
        logic [3:0] stb_cnt;
        logic irq;
        logic sck_s1;
        logic sck_s2;
        logic sck_prev;
        logic si_s1;
        logic si_s2;
        logic busy_s1;
        logic busy_s2;
        logic tog_s1;
        logic tog_s2;
        logic tog_prev;
    } sys_state_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic bit_in;
        logic tog;
    } link_state_t;

endpackage

// ==== three_wire_serial_channel.sv ====
// three-wire serial channel: control register, shift register, serial clock and pins
// assumes the cpu bus and timer ticks run on CLK_SYS; SCK_LINK is the pin clock
`timescale 1ns/100ps
`include "three_wire_serial_defs.svh"
module three_wire_serial_channel
    import three_wire_serial_pkg::*;
#(
    parameter int WORD_BITS = `BITS_PER_WORD
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [15:0] BUS_ADDR,
    input wire logic BUS_WR,
    input wire logic [7:0] BUS_WDATA,
    output logic [7:0] BUS_RDATA,
    input wire logic TIMER_TWO_TICK,
    input wire logic TIMER_SEL_TICK,
    input wire logic SCK_LINK,
    input wire logic SCK_IN,
    output logic SCK_OUT,
    output logic SCK_OE_N,
    input wire logic SI_IN,
    output logic SO_OUT,
    output logic SO_OE_N,
    output logic STB_OUT,
    output logic STB_OE_N,
    input wire logic BUSY_IN,
    output logic TRANSFER_DONE_IRQ,
    input wire logic IRQ_CLEAR
);

    // the shift path and the bit reversal are built for 8-bit words only
    if (WORD_BITS != 8) begin : g_width_check
        $error("only 8-bit words are supported");
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
        end
        return r;
    endfunction

    sys_state_t st;
    sys_state_t next_st;
    link_state_t lk;
    link_state_t next_lk;

    logic enable;
    logic dir_lsb;
    logic auto_mode;
    logic internal_clk;
    logic tick;
    logic wr_ctrl;
    logic wr_shift;
    logic fall_ev;
    logic rise_ev;
    logic rx_bit;
    logic irq_set;

    // ----------------------------------------
    // link domain: capture on pin clock rising edge
    // ----------------------------------------
    // the sys side reads bit_in only after the toggle has crossed, so it is stable
    always_comb begin
        next_lk = lk;
        next_lk.rst_s1 = RST;
        next_lk.rst_s2 = lk.rst_s1;
        if (lk.rst_s2) begin
            next_lk.bit_in = 1'b0;
            next_lk.tog = 1'b0;
        end else begin
            next_lk.bit_in = SI_IN;
            next_lk.tog = ~lk.tog;
        end
    end

    always_ff @(posedge SCK_LINK) begin
        lk <= next_lk;
    end

    // ----------------------------------------
    // system domain
    // ----------------------------------------
    assign enable = st.ctrl[`SMC_ENABLE_BIT];
    assign dir_lsb = st.ctrl[`SMC_DIR_BIT];
    assign auto_mode = st.ctrl[`SMC_AUTO_BIT];
    assign internal_clk = st.ctrl[`SMC_CLK_HI_BIT];
    assign tick = st.ctrl[`SMC_CLK_LO_BIT] ? TIMER_SEL_TICK : TIMER_TWO_TICK;
    assign wr_ctrl = BUS_WR && (BUS_ADDR == `SMC_OFFSET);
    assign wr_shift = BUS_WR && (BUS_ADDR == `SHIFT_OFFSET);

    always_comb begin
        next_st = st;
        fall_ev = 1'b0;
        rise_ev = 1'b0;
        rx_bit = st.si_s2;
        irq_set = 1'b0;
        // pin synchronisers; first stages feed only the second
        next_st.sck_s1 = SCK_IN;
        next_st.sck_s2 = st.sck_s1;
        next_st.sck_prev = st.sck_s2;
        next_st.si_s1 = SI_IN;
        next_st.si_s2 = st.si_s1;
        next_st.busy_s1 = BUSY_IN;
        next_st.busy_s2 = st.busy_s1;
        next_st.tog_s1 = lk.tog;
        next_st.tog_s2 = st.tog_s1;
        next_st.tog_prev = st.tog_s2;

        // edge sources: own divider in internal mode, pin otherwise
        if (internal_clk) begin
            // busy input holds off the next falling edge in automatic mode
            fall_ev = tick && st.sck_o && !(auto_mode && st.busy_s2);
            rise_ev = tick && !st.sck_o;
        end else begin
            fall_ev = st.sck_prev && !st.sck_s2;
            rise_ev = st.tog_s2 != st.tog_prev;
            rx_bit = lk.bit_in;
        end

        if (st.stb_cnt != 4'h0) begin
            next_st.stb_cnt = st.stb_cnt - 4'h1;
        end

        // mode register write; reserved bits stay zero
        // mode bit stored; with internal clock it steers strobe and busy
        if (wr_ctrl) begin
            next_st.ctrl = BUS_WDATA & `SMC_WRITE_MASK;
        end

        if (st.state == XS_RUN && enable) begin
            // shift out on falling edge into the output latch
            if (fall_ev) begin
                next_st.so = st.sreg[7];
                if (internal_clk) begin
                    next_st.sck_o = 1'b0;
                end
            end
            // one bit per serial clock, eight per word
            if (rise_ev) begin
                next_st.sreg = {st.sreg[6:0], rx_bit};
                next_st.cnt = st.cnt + 4'h1;
                if (internal_clk) begin
                    next_st.sck_o = 1'b1;
                end
                // stop after eight bits and flag
                if (st.cnt == 4'(WORD_BITS - 1)) begin
                    next_st.state = XS_IDLE;
                    next_st.cnt = 4'h0;
                    next_st.irq = 1'b1;
                    irq_set = 1'b1;
                    // with internal clock, each byte of an automatic run ends with a strobe
                    if (auto_mode && internal_clk) begin
                        next_st.stb_cnt = 4'(`STROBE_CYCLES);
                    end
                end
            end
        end

        // write path reversed when LSB first
        if (wr_shift) begin
            next_st.sreg = dir_lsb ? rev8(BUS_WDATA) : BUS_WDATA;
            next_st.so = 1'b0;
            // start only if enabled and clock idle high
            // only a write starts; enabling later does nothing
            if (enable && st.state == XS_IDLE && (internal_clk || st.sck_s2)) begin
                next_st.state = XS_RUN;
                next_st.cnt = 4'h0;
            end
        end

        // strobe follows its counter, so a fresh load shows in the same cycle
        next_st.stb = next_st.stb_cnt != 4'h0;

        if (!next_st.ctrl[`SMC_ENABLE_BIT]) begin
            next_st.state = XS_IDLE;
            next_st.cnt = 4'h0;
            next_st.stb_cnt = 4'h0;
            next_st.stb = 1'b0;
        end
        if (next_st.state == XS_IDLE) begin
            next_st.sck_o = 1'b1;
        end

        next_st.so_oe_n = !next_st.ctrl[`SMC_ENABLE_BIT];
        next_st.sck_oe_n = !(next_st.ctrl[`SMC_ENABLE_BIT] && next_st.ctrl[`SMC_CLK_HI_BIT]);
        next_st.stb_oe_n = !(next_st.ctrl[`SMC_ENABLE_BIT] && next_st.ctrl[`SMC_AUTO_BIT]
            && next_st.ctrl[`SMC_CLK_HI_BIT]);

        // done flag: a new set wins over a clear in the same cycle
        if (IRQ_CLEAR && !irq_set) begin
            next_st.irq = 1'b0;
        end

        // read path reversed when LSB first
        case (BUS_ADDR)
            `SMC_OFFSET: next_st.rdata = st.ctrl;
            `SHIFT_OFFSET: next_st.rdata = dir_lsb ? rev8(st.sreg) : st.sreg;
            default: next_st.rdata = 8'h00;
        endcase

        if (RST) begin
            next_st = '0;
            next_st.ctrl = `SMC_RESET;
            next_st.state = XS_IDLE;
            next_st.sck_o = 1'b1;
            next_st.so_oe_n = 1'b1;
            next_st.sck_oe_n = 1'b1;
            next_st.stb_oe_n = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        st <= next_st;
    end

    assign BUS_RDATA = st.rdata;
    assign SCK_OUT = st.sck_o;
    assign SCK_OE_N = st.sck_oe_n;
    assign SO_OUT = st.so;
    assign SO_OE_N = st.so_oe_n;
    assign STB_OUT = st.stb;
    assign STB_OE_N = st.stb_oe_n;
    assign TRANSFER_DONE_IRQ = st.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    reset_clears_ctrl_a: assert property (
        @(posedge CLK_SYS) disable iff (1'b0) RST |=> st.ctrl == 8'h00)
        else $error("control not cleared by reset");

    write_so_low_a: assert property (wr_shift |=> !SO_OUT)
        else $error("serial output not low after shift write");

    no_start_off_a: assert property (wr_shift && !enable |=> st.state == XS_IDLE)
        else $error("transfer started while disabled");

    late_enable_a: assert property (
        st.state == XS_IDLE && !wr_shift |=> st.state == XS_IDLE)
        else $error("transfer started without a write");

    // eighth rising edge ends the word
    done_sets_irq_a: assert property (
        st.state == XS_RUN && enable && !wr_ctrl && rise_ev && st.cnt == 4'h7
        |=> TRANSFER_DONE_IRQ && st.state == XS_IDLE)
        else $error("word end did not set the done flag");

    // a fresh set survives a clear in the same cycle
    irq_set_wins_a: assert property (irq_set |=> TRANSFER_DONE_IRQ)
        else $error("done flag lost to a clear");

    disabled_idle_a: assert property (
        !enable |-> st.cnt == 4'h0 && SO_OE_N && SCK_OE_N && STB_OE_N)
        else $error("disabled channel not quiet");

    // internal clock idles high over the next cycles
    sck_idle_high_a: assert property (
        st.state == XS_IDLE && !wr_shift |=> SCK_OUT [*2])
        else $error("serial clock not high while idle");

    lsb_write_a: assert property (
        wr_shift && dir_lsb |=> st.sreg == rev8($past(BUS_WDATA)))
        else $error("LSB-first write not reversed");

    lsb_read_a: assert property (
        BUS_ADDR == `SHIFT_OFFSET && dir_lsb && !wr_shift
        |=> BUS_RDATA == rev8($past(st.sreg)))
        else $error("LSB-first read not reversed");

    // strobe stands four cycles unless the channel is switched off
    strobe_width_a: assert property (
        $rose(STB_OUT) |-> (STB_OUT || !enable) [*4] ##1 !STB_OUT)
        else $error("strobe width wrong");

    word_done_c: cover property (st.state == XS_RUN ##[1:1000] TRANSFER_DONE_IRQ);
    lsb_word_c: cover property (dir_lsb && st.state == XS_RUN ##[1:1000] st.state == XS_IDLE);
    ext_word_c: cover property (!internal_clk && st.state == XS_RUN ##[1:1000] TRANSFER_DONE_IRQ);
    strobe_c: cover property (STB_OUT);

endmodule

// ==== three_wire_serial_peer.sv ====
// peripheral on the far side of the channel: shifts one byte in and one out
// assumes the tb resolves sck onto one wire with a pull-up
`timescale 1ns/100ps
module three_wire_serial_peer (
    input wire logic sck,
    input wire logic so,
    output logic si,
    output logic sck_drv,
    output logic sck_en
);
    logic [7:0] tx;
    logic [7:0] rx;
    int nbits;
    initial begin
        si = 1'b0;
        sck_drv = 1'b1;
        sck_en = 1'b0;
        tx = 8'h00;
        rx = 8'h00;
        nbits = 0;
    end
    task load(input logic [7:0] d);
        tx = d;
        nbits = 0;
    endtask
    always @(negedge sck) begin
        si <= tx[7];
        tx <= {tx[6:0], 1'b0};
    end
    // so taken on rising edge
    // si flips after the last bit so a stale bit is never mistaken for data
    always @(posedge sck) begin
        rx <= {rx[6:0], so};
        nbits <= nbits + 1;
        if (nbits == 7) begin
            si <= ~si;
        end
    end
    // eight pulses, clock stands high and released between frames
    task frame(input int half);
        sck_en = 1'b1;
        repeat (8) begin
            #(half) sck_drv = 1'b0;
            #(half) sck_drv = 1'b1;
        end
        #(half) sck_en = 1'b0;
    endtask
    // a few 6 ns link clocks so the link domain sees reset
    task link_pulses();
        sck_en = 1'b1;
        repeat (4) begin
            #3 sck_drv = 1'b0;
            #3 sck_drv = 1'b1;
        end
        sck_en = 1'b0;
    endtask
endmodule

// ==== three_wire_serial_channel_tb.sv ====
// testbench of the three-wire serial channel, one task per scenario
// assumes the peer model drives si and, in external mode, the clock wire
`timescale 1ns/100ps
`include "three_wire_serial_defs.svh"
module three_wire_serial_channel_tb;
    logic clk_sys, rst, bus_wr, t2_tick, tsel_tick, busy_in, irq_clear;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, rd_val;
    logic sck_out, sck_oe_n, so_out, so_oe_n, stb_out, stb_oe_n, irq, si_w, sck_drv, sck_en;
    logic sck_w;
    int num_errors, n_tests, n_fall, n_stb, tsrc, tcnt;
    // pull-up on the clock wire when nobody drives it
    assign sck_w = !sck_oe_n ? sck_out : (sck_en ? sck_drv : 1'b1);
    three_wire_serial_channel three_wire_serial_channel_i (.CLK_SYS(clk_sys), .RST(rst),
        .BUS_ADDR(bus_addr), .BUS_WR(bus_wr), .BUS_WDATA(bus_wdata), .BUS_RDATA(bus_rdata),
        .TIMER_TWO_TICK(t2_tick), .TIMER_SEL_TICK(tsel_tick), .SCK_LINK(sck_w),
        .SCK_IN(sck_w), .SCK_OUT(sck_out), .SCK_OE_N(sck_oe_n), .SI_IN(si_w),
        .SO_OUT(so_out), .SO_OE_N(so_oe_n), .STB_OUT(stb_out), .STB_OE_N(stb_oe_n),
        .BUSY_IN(busy_in), .TRANSFER_DONE_IRQ(irq), .IRQ_CLEAR(irq_clear));
    three_wire_serial_peer three_wire_serial_peer_i (.sck(sck_w), .so(so_out), .si(si_w),
        .sck_drv(sck_drv), .sck_en(sck_en));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // timer ticks every 8 cycles: leaves room for the 2-flop input sync
    always @(posedge clk_sys) begin
        tcnt <= tcnt + 1;
        t2_tick <= #1 (tsrc == 1) && (tcnt % 8 == 0);
        tsel_tick <= #1 (tsrc == 2) && (tcnt % 8 == 0);
        if (stb_out === 1'b1) n_stb <= n_stb + 1;
    end
    always @(negedge sck_w) n_fall++;
    task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
            num_errors++;
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        bus_addr = a; bus_wdata = d; bus_wr = 1'b1;
        @(posedge clk_sys) #1;
        bus_wr = 1'b0;
    endtask
    task rd(input logic [15:0] a);
        @(posedge clk_sys) #1;
        bus_addr = a;
        repeat (2) @(posedge clk_sys);
        #1 rd_val = bus_rdata;
    endtask
    task wait_irq();
        repeat (400) begin
            @(posedge clk_sys) #1;
            if (irq === 1'b1) break;
        end
        chk({7'h0, irq}, 8'h01, "done flag");
    endtask
    task clr();
        @(posedge clk_sys) #1 irq_clear = 1'b1;
        @(posedge clk_sys) #1 irq_clear = 1'b0;
    endtask
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset();
        rd(`SMC_OFFSET); chk(rd_val, 8'h00, "ctrl reset");
        chk({4'h0, sck_oe_n, so_oe_n, stb_oe_n, sck_out}, 8'h0f, "pins reset");
        $display("t_reset done");
    endtask
    task t_regs();
        wr(`SMC_OFFSET, 8'hff); rd(`SMC_OFFSET); chk(rd_val, 8'he3, "ctrl mask");
        wr(`SMC_OFFSET, 8'h00); n_fall = 0; wr(`SHIFT_OFFSET, 8'h5c);
        rd(`SHIFT_OFFSET); chk(rd_val, 8'h5c, "stopped store");
        rd(16'hff6a); chk(rd_val, 8'h00, "unmapped");
        chk({4'h0, sck_oe_n, so_oe_n, stb_oe_n, 1'b0}, 8'h0e, "released");
        chk(8'(n_fall), 8'h00, "no clock stopped");
        $display("t_regs done");
    endtask
    task t_msb();
        wr(`SMC_OFFSET, 8'h82); three_wire_serial_peer_i.load(8'h3c);
        tsrc = 2; wr(`SHIFT_OFFSET, 8'ha5); n_fall = 0;
        repeat (150) @(posedge clk_sys);
        chk(8'(n_fall), 8'h00, "wrong timer");
        tsrc = 1; wait_irq();
        chk(8'(n_fall), 8'h08, "pulses");
        chk(three_wire_serial_peer_i.rx, 8'ha5, "msb tx");
        rd(`SHIFT_OFFSET); chk(rd_val, 8'h3c, "msb rx");
        clr(); $display("t_msb done");
    endtask
    task t_lsb();
        // order chosen before the data write
        wr(`SMC_OFFSET, 8'hc3);
        three_wire_serial_peer_i.load(8'h12); tsrc = 2;
        wr(`SHIFT_OFFSET, 8'h1e); chk({7'h0, so_out}, 8'h00, "so low");
        n_fall = 0; wait_irq();
        chk(8'(n_fall), 8'h08, "pulses");
        chk(three_wire_serial_peer_i.rx, 8'h78, "lsb tx");
        rd(`SHIFT_OFFSET); chk(rd_val, 8'h48, "lsb rx");
        clr(); $display("t_lsb done");
    endtask
    task t_ext();
        tsrc = 0; wr(`SMC_OFFSET, 8'h80); three_wire_serial_peer_i.load(8'hc3);
        // handshake lines stay idle with the pin clock
        wr(`SHIFT_OFFSET, 8'h5a); busy_in = 1'b0;
        three_wire_serial_peer_i.frame(41); wait_irq();
        chk(three_wire_serial_peer_i.rx, 8'h5a, "ext tx");
        rd(`SHIFT_OFFSET); chk(rd_val, 8'hc3, "ext rx");
        chk({7'h0, sck_oe_n}, 8'h01, "ext sck input");
        clr(); $display("t_ext done");
    endtask
    task t_refuse();
        wr(`SMC_OFFSET, 8'h02); wr(`SHIFT_OFFSET, 8'h77); wr(`SMC_OFFSET, 8'h82);
        tsrc = 1; n_fall = 0; repeat (200) @(posedge clk_sys);
        chk(8'(n_fall), 8'h00, "late enable");
        chk({7'h0, irq}, 8'h00, "late enable irq");
        wr(`SHIFT_OFFSET, 8'h33); repeat (40) @(posedge clk_sys);
        wr(`SMC_OFFSET, 8'h02); n_fall = 0; repeat (100) @(posedge clk_sys);
        chk({6'h0, irq, sck_oe_n}, 8'h01, "abort");
        chk(8'(n_fall), 8'h00, "abort clock");
        // a fresh start after the abort must give a full word, not the leftover count
        wr(`SMC_OFFSET, 8'h82); three_wire_serial_peer_i.load(8'h00);
        wr(`SHIFT_OFFSET, 8'h0f); n_fall = 0; wait_irq();
        chk(8'(n_fall), 8'h08, "restart pulses");
        chk(three_wire_serial_peer_i.rx, 8'h0f, "restart tx");
        clr(); $display("t_refuse done");
    endtask
    task t_auto();
        wr(`SMC_OFFSET, 8'ha2); busy_in = 1'b1;
        // transmit only: the peer sends nothing back
        three_wire_serial_peer_i.load(8'h00);
        wr(`SHIFT_OFFSET, 8'h96); n_fall = 0; n_stb = 0;
        repeat (120) @(posedge clk_sys);
        chk(8'(n_fall), 8'h00, "busy holds");
        #1 busy_in = 1'b0; wait_irq();
        chk(8'(n_fall), 8'h08, "auto pulses");
        chk(three_wire_serial_peer_i.rx, 8'h96, "auto tx");
        repeat (30) @(posedge clk_sys);
        chk(8'(n_stb), 8'(`STROBE_CYCLES), "strobe width");
        chk({7'h0, stb_oe_n}, 8'h00, "strobe driven");
        clr(); $display("t_auto done");
    endtask
    initial begin
        rst = 1'b1; bus_wr = 1'b0; bus_addr = 16'h0000; bus_wdata = 8'h00;
        t2_tick = 1'b0; tsel_tick = 1'b0; busy_in = 1'b0; irq_clear = 1'b0;
        num_errors = 0; n_tests = 0; n_fall = 0; n_stb = 0; tsrc = 0; tcnt = 0;
        // link clock runs alongside so the link side sees reset too
        fork
            three_wire_serial_peer_i.link_pulses();
        join_none
        repeat (5) @(posedge clk_sys);
        #1 rst = 1'b0;
        t_reset(); t_regs(); t_msb(); t_lsb(); t_ext(); t_refuse(); t_auto();
        report_and_stop();
    end
    // watchdog: whole run needs about 1400 cycles
    initial begin
        #60000;
        num_errors++;
        report_and_stop();
    end
endmodule
